//--- core/hmc_defs.vh
`ifndef HMC_DEFS_VH
`define HMC_DEFS_VH

// ==========================================================
// Register placement
// ==========================================================
`define HMC_MISC_OFFSET        8'hf0
`define HMC_MISC_RESET         32'h00000000

// ==========================================================
// Field positions
// ==========================================================
`define HMC_PME_COLD_BIT       15
`define HMC_REV23_BIT          11
`define HMC_PME_IGN_BIT        10
`define HMC_MRSEL_HI           9
`define HMC_MRSEL_LO           8
`define HMC_NO_TABT_BIT        4
`define HMC_GPIO_I2C_BIT       3
`define HMC_LGATE_BYP_BIT      2
`define HMC_HGATE_BYP_BIT      1
`define HMC_KEEP_CLK_BIT       0
`define HMC_VENDOR_PME_BIT     26

// ==========================================================
// Read command select encodings
// ==========================================================
`define HMC_MRSEL_LINE         2'h0
`define HMC_MRSEL_PLAIN        2'h1
`define HMC_MRSEL_MULT         2'h2

// ==========================================================
// Bus command codes
// ==========================================================
`define HMC_CMD_MEM_READ       4'h6
`define HMC_CMD_MEM_READ_MULT  4'hc
`define HMC_CMD_MEM_READ_LINE  4'he
`define HMC_SHORT_PHASES       8'h02

// ==========================================================
// Link access answers and timing
// ==========================================================
`define HMC_STOPPED_DATA       32'hffffffff
`define HMC_CLKRUN_HOLD        4'h4

`endif

//--- core/hmc_cmd_sel.v
`timescale 1ns/100ps
`default_nettype none

module hmc_cmd_sel (
    input  wire [1:0] sel,
    input  wire [7:0] phases,
    output wire [3:0] cmd
);

`include "hmc_defs.vh"

// ==========================================================
// Command choice
// ==========================================================
function [3:0] hmc_pick;
    input [1:0] s;
    input [7:0] n;
    begin
        if (n <= `HMC_SHORT_PHASES) begin
            hmc_pick = `HMC_CMD_MEM_READ;
        end else begin
            case (s)
                `HMC_MRSEL_PLAIN: hmc_pick = `HMC_CMD_MEM_READ;
                `HMC_MRSEL_MULT:  hmc_pick = `HMC_CMD_MEM_READ_MULT;
                // Reserved code falls back to the default command
                default:          hmc_pick = `HMC_CMD_MEM_READ_LINE;
            endcase
        end
    end
endfunction

assign cmd = hmc_pick(sel, phases);

endmodule // hmc_cmd_sel
`default_nettype wire

//--- core/hmc_misc_cfg.v
// Functional notes
// - Bits 31..16 and 14..12 always read back as zero.
// - Bit 15 is mirrored into the power capability bit 15.
// - Bit 11 enables revision 2.3 interrupt disable and status bits.
// - Bit 10 makes power events ignore the master interrupt enable.
// - Bit 10 also shows as vendor identification bit 26.
// - Long master reads use the command chosen by bits 9..8.
// - Reads of one or two data phases always use plain read.
// - Bits 9..8 load from serial memory word 12 bits 1..0.
// - Bits 7..5 always read back as zero.
// - Bit 4 set returns data instead of signalling target abort.
// - Link access with stopped link clock aborts, or returns all ones.
// - Bit 3 routes gpio three and two to the two-wire bus, pins off.
// - Bit 2 runs the link clock ungated; software keeps it clear.
// - Bit 1 runs the host clock ungated; software keeps it clear.
// - Bit 0 holds the host clock running through the clock-run pin.
// - Register clears to zero only on the global reset pin.
`timescale 1ns/100ps
`default_nettype none

module hmc_misc_cfg (
    input  wire        clk,
    input  wire        rst_b,
    // Configuration access
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [7:0]  cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata,
    output reg         cfg_hit,
    // Serial configuration memory load
    input  wire        eeprom_load,
    input  wire [7:0]  eeprom_word12,
    // Interrupt and power event
    input  wire        irq_pending,
    input  wire        int_disable_bit,
    input  wire        unmasked_irq_any,
    input  wire        master_interrupt_enable_bit,
    input  wire        pme_enable,
    output wire        irq_out,
    output wire        interrupt_status_bit,
    output wire        pme_request,
    output wire        pme_from_cold_support,
    output wire        bus_rev_23_enable,
    output wire        vendor_id_bit26,
    // Bus master read command
    input  wire [7:0]  mst_read_phases,
    output reg  [3:0]  mst_read_cmd,
    // Link register access
    input  wire        link_acc_req,
    input  wire        link_clk_running,
    input  wire        link_ack,
    input  wire [31:0] link_rdata,
    output wire        link_req,
    output reg         acc_done,
    output reg         acc_abort,
    output reg  [31:0] acc_rdata,
    // General purpose pins and two-wire bus
    input  wire        gpio_pin_three_i,
    input  wire        gpio_pin_two_i,
    input  wire        gpio_three_drv,
    input  wire        gpio_three_oe_req,
    input  wire        gpio_two_drv,
    input  wire        gpio_two_oe_req,
    output wire        gpio_pin_three_o,
    output wire        gpio_pin_three_oe,
    output wire        gpio_pin_two_o,
    output wire        gpio_pin_two_oe,
    output wire        twowire_scl_in,
    output wire        twowire_sda_in,
    // Clock gating
    input  wire        link_gate_req,
    input  wire        host_gate_req,
    output wire        link_clock_run,
    output wire        host_clock_run,
    // Clock-run pin
    input  wire        multifunction_pin_six_i,
    output wire        multifunction_pin_six_o,
    output wire        multifunction_pin_six_oe
);

`include "hmc_defs.vh"

// ==========================================================
// Stored fields
// ==========================================================
reg        pme_cold_r;
reg        rev23_r;
reg        pme_ign_r;
reg  [1:0] mrsel_r;
reg        no_tabt_r;
reg        gpio_i2c_r;
reg        lgate_byp_r;
reg        hgate_byp_r;
reg        keep_clk_r;

wire       sel_hit;
wire       wr_lo;
wire       wr_hi;
wire [3:0] cmd_nxt;

assign sel_hit = (cfg_addr == `HMC_MISC_OFFSET);
assign wr_lo   = cfg_wr & sel_hit & cfg_be[0];
assign wr_hi   = cfg_wr & sel_hit & cfg_be[1];

function [31:0] hmc_image;
    input        pc;
    input        r23;
    input        pig;
    input [1:0]  ms;
    input        nt;
    input        gi;
    input        lb;
    input        hb;
    input        kc;
    begin
        hmc_image = 32'h00000000;
        hmc_image[`HMC_PME_COLD_BIT] = pc;
        hmc_image[`HMC_REV23_BIT]    = r23;
        hmc_image[`HMC_PME_IGN_BIT]  = pig;
        hmc_image[`HMC_MRSEL_HI:`HMC_MRSEL_LO] = ms;
        hmc_image[`HMC_NO_TABT_BIT]  = nt;
        hmc_image[`HMC_GPIO_I2C_BIT] = gi;
        hmc_image[`HMC_LGATE_BYP_BIT] = lb;
        hmc_image[`HMC_HGATE_BYP_BIT] = hb;
        hmc_image[`HMC_KEEP_CLK_BIT] = kc;
    end
endfunction

// ==========================================================
// Register writes
// ==========================================================
// Global reset only
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        pme_cold_r  <= 1'b0;
        rev23_r     <= 1'b0;
        pme_ign_r   <= 1'b0;
        mrsel_r     <= 2'h0;
        no_tabt_r   <= 1'b0;
        gpio_i2c_r  <= 1'b0;
        lgate_byp_r <= 1'b0;
        hgate_byp_r <= 1'b0;
        keep_clk_r  <= 1'b0;
    end else begin
        if (wr_lo) begin
            no_tabt_r   <= cfg_wdata[`HMC_NO_TABT_BIT];
            gpio_i2c_r  <= cfg_wdata[`HMC_GPIO_I2C_BIT];
            lgate_byp_r <= cfg_wdata[`HMC_LGATE_BYP_BIT];
            hgate_byp_r <= cfg_wdata[`HMC_HGATE_BYP_BIT];
            keep_clk_r  <= cfg_wdata[`HMC_KEEP_CLK_BIT];
        end
        if (wr_hi) begin
            pme_cold_r <= cfg_wdata[`HMC_PME_COLD_BIT];
            rev23_r    <= cfg_wdata[`HMC_REV23_BIT];
            pme_ign_r  <= cfg_wdata[`HMC_PME_IGN_BIT];
        end
        // Serial memory load
        // Load wins over a host write in the same cycle: loading runs
        // before software can reach the register
        if (eeprom_load) begin
            mrsel_r <= eeprom_word12[1:0];
        end else if (wr_hi) begin
            mrsel_r <= cfg_wdata[`HMC_MRSEL_HI:`HMC_MRSEL_LO];
        end
    end
end

// ==========================================================
// Register reads
// ==========================================================
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        cfg_rdata <= 32'h00000000;
        cfg_hit   <= 1'b0;
    end else begin
        cfg_hit <= cfg_rd & sel_hit;
        if (cfg_rd) begin
            cfg_rdata <= sel_hit ?
                hmc_image(pme_cold_r, rev23_r, pme_ign_r, mrsel_r,
                          no_tabt_r, gpio_i2c_r, lgate_byp_r,
                          hgate_byp_r, keep_clk_r) : 32'h00000000;
        end
    end
end

// ==========================================================
// Interrupt and power event
// ==========================================================
// Cold support mirror
assign pme_from_cold_support = pme_cold_r;
assign bus_rev_23_enable     = rev23_r;
assign irq_out              = irq_pending & ~(rev23_r & int_disable_bit);
assign interrupt_status_bit = rev23_r & irq_pending;
assign pme_request = pme_enable & unmasked_irq_any &
                     (pme_ign_r | master_interrupt_enable_bit);
assign vendor_id_bit26 = pme_ign_r;

// ==========================================================
// Master read command
// ==========================================================
hmc_cmd_sel u_cmd_sel (
    .sel    (mrsel_r),
    .phases (mst_read_phases),
    .cmd    (cmd_nxt)
);

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        mst_read_cmd <= `HMC_CMD_MEM_READ;
    end else begin
        mst_read_cmd <= cmd_nxt;
    end
end

// ==========================================================
// Link register access
// ==========================================================
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_WAIT = 2'h1;

reg [1:0] acc_st_r;
reg [1:0] acc_st_nxt;

// A request taken while idle goes to the link only if its clock runs
assign link_req = (acc_st_r == ST_IDLE) & link_acc_req & link_clk_running;

always @* begin
    acc_st_nxt = acc_st_r;
    case (acc_st_r)
        ST_IDLE: begin
            if (link_req) begin
                acc_st_nxt = ST_WAIT;
            end
        end
        ST_WAIT: begin
            // A clock stopping mid-access must not hang the host
            if (link_ack | ~link_clk_running) begin
                acc_st_nxt = ST_IDLE;
            end
        end
        default: acc_st_nxt = ST_IDLE;
    endcase
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        acc_st_r  <= ST_IDLE;
        acc_done  <= 1'b0;
        acc_abort <= 1'b0;
        acc_rdata <= 32'h00000000;
    end else begin
        acc_st_r  <= acc_st_nxt;
        acc_done  <= 1'b0;
        acc_abort <= 1'b0;
        if ((acc_st_r == ST_WAIT) & link_ack & link_clk_running) begin
            acc_done  <= 1'b1;
            acc_rdata <= link_rdata;
        end else if (((acc_st_r == ST_IDLE) & link_acc_req) |
                     (acc_st_r == ST_WAIT)) begin
            if (~link_clk_running) begin
                if (no_tabt_r) begin
                    acc_done  <= 1'b1;
                    acc_rdata <= `HMC_STOPPED_DATA;
                end else begin
                    acc_abort <= 1'b1;
                end
            end
        end
    end
end

// ==========================================================
// Pins and clocks
// ==========================================================
// Two-wire routing
assign gpio_pin_three_o  = gpio_three_drv;
assign gpio_pin_three_oe = gpio_three_oe_req & ~gpio_i2c_r;
assign gpio_pin_two_o    = gpio_two_drv;
assign gpio_pin_two_oe   = gpio_two_oe_req & ~gpio_i2c_r;
// Idle two-wire lines float high when not routed
assign twowire_scl_in    = gpio_i2c_r ? gpio_pin_three_i : 1'b1;
assign twowire_sda_in    = gpio_i2c_r ? gpio_pin_two_i : 1'b1;

assign link_clock_run = lgate_byp_r | link_gate_req;
assign host_clock_run = hgate_byp_r | host_gate_req;

// ==========================================================
// Clock-run pin
// ==========================================================
reg [3:0] crun_cnt_r;

// Keep clock running
// The pin is pulled low for a fixed hold whenever the host releases it,
// which restarts the clock before the host may stop it
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        crun_cnt_r <= 4'h0;
    end else if (crun_cnt_r != 4'h0) begin
        crun_cnt_r <= crun_cnt_r - 4'h1;
    end else if (keep_clk_r & multifunction_pin_six_i) begin
        crun_cnt_r <= `HMC_CLKRUN_HOLD;
    end
end

assign multifunction_pin_six_o  = 1'b0;
assign multifunction_pin_six_oe = (crun_cnt_r != 4'h0);

endmodule // hmc_misc_cfg
`default_nettype wire

//--- verif/hmc_link_model.sv
`timescale 1ns/100ps
`default_nettype none

module hmc_link_model #(
    parameter logic [31:0] WORD = 32'h3c5a0f96
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        link_req,
    input  wire logic [3:0]  wait_cycles,
    output logic             link_ack,
    output logic      [31:0] link_rdata
);
    logic       busy_r;
    logic [3:0] cnt_r;

    // ==========
    // Answer after a set delay, zero means prompt
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            link_ack <= 1'b0;
        end else begin
            link_ack <= busy_r && cnt_r == 4'h0;
            if (link_req && !busy_r) begin
                busy_r <= 1'b1;
                cnt_r <= wait_cycles;
            end else if (busy_r && cnt_r == 4'h0) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end

    // Released data lines show the inverse so stale data never passes
    assign link_rdata = link_ack ? WORD : ~WORD;
endmodule // hmc_link_model

`default_nettype wire

//--- verif/hmc_misc_cfg_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module hmc_chk (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        cfg_hit,
    input wire logic [31:0] cfg_rdata,
    input wire logic        pme_from_cold_support,
    input wire logic        bus_rev_23_enable,
    input wire logic        irq_pending,
    input wire logic        interrupt_status_bit,
    input wire logic [7:0]  mst_read_phases,
    input wire logic [3:0]  mst_read_cmd,
    input wire logic        link_clk_running,
    input wire logic        acc_done,
    input wire logic        acc_abort,
    input wire logic [31:0] acc_rdata,
    input wire logic        gpio_pin_three_oe,
    input wire logic        twowire_scl_in,
    input wire logic        multifunction_pin_six_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ==========
    // Readback and mirrors
    AST_RSVD_HIGH: assert property (cfg_hit |->
        cfg_rdata[31:16] == 16'h0 && cfg_rdata[14:12] == 3'h0)
        else $error("upper reserved bits read nonzero");
    AST_RSVD_LOW: assert property (cfg_hit |-> cfg_rdata[7:5] == 3'h0)
        else $error("low reserved bits read nonzero");
    AST_COLD_COPY: assert property (cfg_hit |->
        pme_from_cold_support == cfg_rdata[15])
        else $error("cold power bit differs from register");
    AST_REV_STATUS: assert property (interrupt_status_bit ==
        (bus_rev_23_enable && irq_pending))
        else $error("status bit wrong for revision mode");

    // ==========
    // Master reads and link access
    AST_SHORT_READ: assert property (mst_read_phases <= 8'h02 |=>
        mst_read_cmd == 4'h6) else $error("short read not plain");
    AST_ABORT_CAUSE: assert property (acc_abort |->
        !$past(link_clk_running)) else $error("abort with clock running");
    AST_STOP_DATA: assert property (acc_done &&
        !$past(link_clk_running) |-> acc_rdata == 32'hffffffff)
        else $error("stopped clock data not all ones");

    // ==========
    // Pins
    AST_GPIO_ROUTE: assert property (gpio_pin_three_oe |->
        twowire_scl_in) else $error("pin driven while routed");
    AST_CLKRUN_HOLD: assert property ($rose(multifunction_pin_six_oe) |->
        multifunction_pin_six_oe[*4]) else $error("clock run hold short");

    COV_ABORT: cover property (acc_abort);
    COV_STOP_DONE: cover property (acc_done && !$past(link_clk_running));
    COV_CLKRUN: cover property ($rose(multifunction_pin_six_oe));
endmodule // hmc_chk

bind hmc_misc_cfg hmc_chk u_chk (.clk, .rst_b, .cfg_hit, .cfg_rdata,
    .pme_from_cold_support, .bus_rev_23_enable, .irq_pending,
    .interrupt_status_bit, .mst_read_phases, .mst_read_cmd,
    .link_clk_running, .acc_done, .acc_abort, .acc_rdata,
    .gpio_pin_three_oe, .twowire_scl_in, .multifunction_pin_six_oe);

`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam logic [31:0] LW = 32'h3c5a0f96;
    localparam logic [15:0] LONG_CMDS = 16'hec6e;
    logic        clk, rst_b, cfg_wr, cfg_rd, cfg_hit, eeprom_load, six_ext;
    logic        irq_pending, int_disable_bit, unmasked_irq_any, pme_enable;
    logic        master_interrupt_enable_bit, irq_out, interrupt_status_bit;
    logic        pme_request, pme_from_cold_support, bus_rev_23_enable;
    logic        vendor_id_bit26, link_acc_req, link_clk_running, link_ack;
    logic        link_req, acc_done, acc_abort, gpio_pin_three_i;
    logic        gpio_pin_two_i, gpio_three_drv, gpio_three_oe_req;
    logic        gpio_two_drv, gpio_two_oe_req, gpio_pin_three_o;
    logic        gpio_pin_three_oe, gpio_pin_two_o, gpio_pin_two_oe;
    logic        twowire_scl_in, twowire_sda_in, link_gate_req, host_gate_req;
    logic        link_clock_run, host_clock_run, multifunction_pin_six_o;
    logic        multifunction_pin_six_oe;
    wire         multifunction_pin_six_i;
    logic [3:0]  cfg_be, mst_read_cmd, link_wait;
    logic [7:0]  cfg_addr, eeprom_word12, mst_read_phases;
    logic [31:0] cfg_wdata, cfg_rdata, link_rdata, acc_rdata;
    integer      miscompares, compares, cycles, i, n;

    hmc_misc_cfg DUT (.clk, .rst_b, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
        .cfg_wdata, .cfg_rdata, .cfg_hit, .eeprom_load, .eeprom_word12,
        .irq_pending, .int_disable_bit, .unmasked_irq_any,
        .master_interrupt_enable_bit, .pme_enable, .irq_out,
        .interrupt_status_bit, .pme_request, .pme_from_cold_support,
        .bus_rev_23_enable, .vendor_id_bit26, .mst_read_phases,
        .mst_read_cmd, .link_acc_req, .link_clk_running, .link_ack,
        .link_rdata, .link_req, .acc_done, .acc_abort, .acc_rdata,
        .gpio_pin_three_i, .gpio_pin_two_i, .gpio_three_drv,
        .gpio_three_oe_req, .gpio_two_drv, .gpio_two_oe_req,
        .gpio_pin_three_o, .gpio_pin_three_oe, .gpio_pin_two_o,
        .gpio_pin_two_oe, .twowire_scl_in, .twowire_sda_in, .link_gate_req,
        .host_gate_req, .link_clock_run, .host_clock_run,
        .multifunction_pin_six_i, .multifunction_pin_six_o,
        .multifunction_pin_six_oe);
    hmc_link_model #(.WORD(LW)) u_link (.clk, .rst_b, .link_req,
        .wait_cycles(link_wait), .link_ack, .link_rdata);

    // Open-drain clock-run line: device pulls low, else the host level
    assign multifunction_pin_six_i =
        multifunction_pin_six_oe ? multifunction_pin_six_o : six_ext;

    always #4 clk = ~clk;

    // ==========
    // Shared tasks
    task summarize;
        if (miscompares == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        compares = compares + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task wr(input logic [3:0] be, input logic [31:0] d);
        cfg_wr = 1'b1;
        cfg_addr = 8'hf0;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
        @(negedge clk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd = 1'b0;
        check(cfg_rdata, exp, "cfg_rdata");
        check(32'(cfg_hit), 32'(a == 8'hf0), "cfg_hit");
        @(negedge clk);
    endtask

    task acc(input logic run, input logic ab, input logic [31:0] d);
        link_clk_running = run;
        link_acc_req = 1'b1;
        n = 0;
        @(negedge clk);
        while (acc_done !== 1'b1 && acc_abort !== 1'b1 && n < 20) begin
            @(negedge clk);
            n = n + 1;
        end
        link_acc_req = 1'b0;
        check(32'(acc_abort), 32'(ab), "acc_abort");
        if (!ab) check(acc_rdata, d, "acc_rdata");
        @(negedge clk);
    endtask

    // ==========
    // Scenarios
    task t_regs;
        rd(8'hf0, 32'h0);
        wr(4'hf, 32'hffffffff);
        rd(8'hf0, 32'h8f1f);
        check({pme_from_cold_support, bus_rev_23_enable}, 32'h3,
              "cold");
        check(32'(vendor_id_bit26), 32'h1, "vendor26");
        rd(8'hf4, 32'h0);
        wr(4'h1, 32'h0);
        rd(8'hf0, 32'h8f00);
    endtask

    task t_cmd;
        for (i = 0; i < 4; i = i + 1) begin
            wr(4'hf, 32'(i) << 8);
            mst_read_phases = 8'h03;
            @(negedge clk);
            check(32'(mst_read_cmd), 32'(LONG_CMDS[i*4+:4]), "long");
            mst_read_phases = 8'h02;
            @(negedge clk);
            check(32'(mst_read_cmd), 32'h6, "short cmd");
        end
        eeprom_word12 = 8'hfe;
        eeprom_load = 1'b1;
        @(negedge clk);
        eeprom_load = 1'b0;
        @(negedge clk);
        rd(8'hf0, 32'h200);
    endtask

    task t_irq;
        wr(4'hf, 32'h0);
        {irq_pending, int_disable_bit, pme_enable, unmasked_irq_any} = 4'hf;
        @(negedge clk);
        check({irq_out, interrupt_status_bit, pme_request},
              32'h4, "v22");
        check(32'(vendor_id_bit26), 32'h0, "vendor26 off");
        master_interrupt_enable_bit = 1'b1;
        @(negedge clk);
        check(32'(pme_request), 32'h1, "pme master");
        master_interrupt_enable_bit = 1'b0;
        wr(4'hf, 32'hc00);
        check({irq_out, interrupt_status_bit, pme_request},
              32'h3, "v23");
    endtask

    task t_link;
        wr(4'hf, 32'h0);
        link_wait = 4'h0;
        acc(1'b1, 1'b0, LW);
        link_wait = 4'h3;
        acc(1'b1, 1'b0, LW);
        acc(1'b0, 1'b1, LW);
        wr(4'hf, 32'h10);
        acc(1'b0, 1'b0, 32'hffffffff);
    endtask

    task t_pins;
        wr(4'hf, 32'h8);
        {gpio_pin_three_i, gpio_pin_two_i} = 2'h1;
        {gpio_three_oe_req, gpio_two_oe_req, gpio_three_drv} = 3'h7;
        @(negedge clk);
        check({gpio_pin_three_oe, gpio_pin_two_oe, twowire_scl_in,
               twowire_sda_in}, 32'h1, "routed");
        check({gpio_pin_three_o, gpio_pin_two_o}, 32'h2, "drv");
        wr(4'hf, 32'h6);
        check({gpio_pin_three_oe, twowire_scl_in,
               link_clock_run, host_clock_run}, 32'hf, "bypass");
        wr(4'hf, 32'h1);
        link_gate_req = 1'b1;
        @(negedge clk);
        check({link_clock_run, host_clock_run}, 32'h2, "gated");
        six_ext = 1'b1;
        n = 0;
        repeat (8) begin
            @(negedge clk);
            six_ext = 1'b0;
            n = n + 32'(multifunction_pin_six_oe);
        end
        check(32'(n), 32'h4, "clkrun hold");
        check(32'(multifunction_pin_six_o), 32'h0, "six low");
    endtask

    task t_reset;
        wr(4'hf, 32'hffffffff);
        rst_b = 1'b0;
        @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        rd(8'hf0, 32'h0);
    endtask

    // Cut a hang short well beyond the fewer than a hundred cycles needed
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            summarize;
        end
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        {cfg_wr, cfg_rd, eeprom_load, six_ext, link_acc_req} = '0;
        {irq_pending, int_disable_bit, unmasked_irq_any, pme_enable} = '0;
        {master_interrupt_enable_bit, link_clk_running, link_gate_req} = '0;
        {gpio_pin_three_i, gpio_pin_two_i, gpio_three_drv} = '0;
        {gpio_three_oe_req, gpio_two_drv, gpio_two_oe_req} = '0;
        {host_gate_req, cfg_be, link_wait, cfg_addr} = '0;
        {eeprom_word12, mst_read_phases, cfg_wdata} = '0;
        miscompares = 0;
        compares = 0;
        cycles = 0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_regs;
        t_cmd;
        t_irq;
        t_link;
        t_pins;
        t_reset;
        summarize;
    end
endmodule // tb

`default_nettype wire
